/* cvi_pkg.sv */
// shared constants for the core-voltage two-wire link
package cvi_pkg;
	localparam logic [6:0] DEV_ADDR      = 7'h2C;  // arbitrary default slave address
	localparam int         VCODE_LSB     = 0;      // voltage_code field position
	localparam int         VCODE_W       = 4;
	localparam int         SLEW_LSB      = 4;      // slew_code field position
	localparam int         SLEW_W        = 2;
	localparam logic [3:0] VCODE_RST     = 4'h0;   // voltage_code after reset
	localparam logic [1:0] SLEW_RST      = 2'h1;   // slew_code after reset
	localparam logic [7:0] PROG_USED     = 8'h3F;  // bits 6..7 unused
	// master timing: link clock half period in MCLK cycles
	localparam real        CLK_NS        = 5.0;
	localparam real        HALF_NS       = 32.0;
	localparam int         HALF_CYC      = int'(HALF_NS / CLK_NS);
	// host register map (AXI4-Lite byte addresses)
	localparam logic [3:0] REG_CMD       = 4'h0;   // [7:0] data, [8] read, [6:0]@16 addr, write starts
	localparam logic [3:0] REG_STATUS    = 4'h4;   // [0] busy, [1] nack, [15:8] read data
	localparam int         CMD_RD_BIT    = 8;
	localparam int         CMD_ADDR_LSB  = 16;
	localparam logic [1:0] RESP_OKAY     = 2'b00;
	localparam logic [1:0] RESP_SLVERR   = 2'b10;
endpackage

/* cvi_if.sv */
// two-wire link between host master and voltage device
`timescale 1ns/10ps
`default_nettype none
interface cvi_if;
	logic scl_o;     // clock driven by master
	logic scl_oe;    // master drives clock low
	logic sda_m_o;   // master data out
	logic sda_m_oe;  // master pulls data low
	logic sda_s_o;   // slave data out
	logic sda_s_oe;  // slave pulls data low
	wire  scl = !(scl_oe && !scl_o);
	wire  sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
	modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe, input scl, sda);
	modport slave  (output sda_s_o, sda_s_oe, input scl, sda);
endinterface
`default_nettype wire

/* cvi_device.sv */
// voltage device end: two-wire slave with program register
`timescale 1ns/10ps
`default_nettype none
module cvi_device
	import cvi_pkg::*;
(
	input  wire logic       MCLK,           // system clock
	input  wire logic       RST,            // sync reset, high
	cvi_if.slave            BUS,            // two-wire link
	output logic [3:0]      VOLTAGE_SELECT, // code to reference DAC
	output logic [3:0]      SOFT_SRC_EN,    // one-hot soft-start source
	output logic [7:0]      PROGRAM_REG     // program register view
);
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_RECV = 5'b00010,
		S_ACK  = 5'b00100,
		S_SEND = 5'b01000,
		S_RACK = 5'b10000
	} st_t;

	typedef struct packed {
		logic [1:0] scl_s;   // scl synchroniser
		logic [1:0] sda_s;   // sda synchroniser
		logic       scl_p;   // previous synced scl
		logic       sda_p;   // previous synced sda
		st_t        st;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic       addr_ph; // receiving address byte
		logic       rd;      // read transfer
		logic       drv;     // pulling sda low
		logic [7:0] prog;
		logic [3:0] src;     // one-hot soft-start source
	} state_t;

	state_t s_q, s_d;
	logic scl, sda, rise, fall, start, stop;
	logic addr_hit;  // received address is ours
	logic byte_end;  // eighth bit of a byte has ended

	////////////////////////////////////////////////////////////////////////
	// edge and condition detection on synced lines
	assign scl   = s_q.scl_s[1];
	assign sda   = s_q.sda_s[1];
	assign rise  = scl && !s_q.scl_p;
	assign fall  = !scl && s_q.scl_p;
	// a condition needs scl high on two samples in a row, so an sda edge
	// launched together with a scl fall is never taken for start or stop
	assign start = scl && s_q.scl_p && s_q.sda_p && !sda;
	assign stop  = scl && s_q.scl_p && !s_q.sda_p && sda;

	// byte boundary and address compare
	assign addr_hit = (s_q.sh[7:1] == DEV_ADDR);
	assign byte_end = fall && (s_q.bitn == 4'h8);

	////////////////////////////////////////////////////////////////////////
	// next state; slow sampling covers standard and fast rates alike
	// limitation: each scl half period must span at least four MCLK cycles
	always_comb begin
		s_d = s_q;
		// two-flop synchronisers on both pins; only the second stage is read
		s_d.scl_s = {s_q.scl_s[0], BUS.scl};
		s_d.sda_s = {s_q.sda_s[0], BUS.sda};
		s_d.scl_p = scl;
		s_d.sda_p = sda;
		if (start) begin
			// any start, a repeated one too, restarts the address phase
			s_d.st = S_RECV;
			s_d.bitn = 4'h0;
			s_d.addr_ph = 1'b1;
			s_d.drv = 1'b0;
		end else if (stop) begin
			s_d.st = S_IDLE;
			s_d.drv = 1'b0;
		end else begin
			case (s_q.st)
				S_IDLE: begin
					// mismatched or finished: stay off the bus until the next start
					s_d.drv = 1'b0;
				end

				S_RECV: begin
					if (rise) begin
						s_d.sh = {s_q.sh[6:0], sda};
						s_d.bitn = s_q.bitn + 4'h1;
					end
					if (byte_end) begin
						if (s_q.addr_ph) begin
							if (addr_hit) begin
								s_d.drv = 1'b1;
								s_d.rd = s_q.sh[0];
								s_d.st = S_ACK;
							end else begin
								s_d.st = S_IDLE;
							end
						end else begin
							s_d.drv = 1'b1;
							s_d.st = S_ACK;
						end
					end
				end

				S_ACK: begin
					// data byte latched at ack clock rise
					if (rise && !s_q.addr_ph) begin
						s_d.prog = s_q.sh & PROG_USED;
					end
					if (fall) begin
						s_d.bitn = 4'h0;
						if (s_q.addr_ph && s_q.rd) begin
							s_d.st = S_SEND;
							s_d.sh = s_q.prog;
							s_d.drv = !s_q.prog[7];
						end else begin
							s_d.st = S_RECV;
							s_d.drv = 1'b0;
						end
						s_d.addr_ph = 1'b0;
					end
				end

				S_SEND: begin
					// next bit launched on the synced fall, well inside scl low
					if (fall) begin
						s_d.bitn = s_q.bitn + 4'h1;
						if (s_q.bitn == 4'h7) begin
							s_d.drv = 1'b0;
							s_d.st = S_RACK;
						end else begin
							s_d.sh = {s_q.sh[6:0], 1'b0};
							s_d.drv = !s_q.sh[6];
						end
					end
				end

				S_RACK: begin
					// master nack ends the read; ack repeats the register
					if (rise) begin
						s_d.rd = !sda;
					end
					if (fall) begin
						s_d.bitn = 4'h0;
						if (s_q.rd) begin
							s_d.st = S_SEND;
							s_d.sh = s_q.prog;
							s_d.drv = !s_q.prog[7];
						end else begin
							s_d.st = S_IDLE;
						end
					end
				end
				default: s_d.st = S_IDLE;
			endcase
		end
		// one-hot decode of the next slew code, registered so the
		// soft-start pin never sees a decode glitch
		s_d.src = 4'h0;
		s_d.src[s_d.prog[SLEW_LSB +: SLEW_W]] = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// state register; lines reset to released and high, so no false edge
	// or condition is seen in the first cycles after reset
	always_ff @(posedge MCLK) begin
		if (RST) begin
			s_q <= '0;
			s_q.scl_s <= 2'b11;
			s_q.sda_s <= 2'b11;
			s_q.scl_p <= 1'b1;
			s_q.sda_p <= 1'b1;
			s_q.st <= S_IDLE;
			s_q.prog <= {2'b00, SLEW_RST, VCODE_RST};
			s_q.src <= 4'h1 << SLEW_RST;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs: open-drain sda, register fields
	// the device only ever pulls the data line low, never drives it high
	assign BUS.sda_s_o  = 1'b0;
	assign BUS.sda_s_oe = s_q.drv;
	assign VOLTAGE_SELECT = s_q.prog[VCODE_LSB +: VCODE_W];
	assign PROGRAM_REG = s_q.prog;
	assign SOFT_SRC_EN = s_q.src;
endmodule
`default_nettype wire

/* cvi_host.sv */
// host end: AXI4-Lite controlled two-wire master
`timescale 1ns/10ps
`default_nettype none
module cvi_host
	import cvi_pkg::*;
(
	input  wire logic        MCLK,    // system clock
	input  wire logic        RST,     // sync reset, high
	cvi_if.master            BUS,     // two-wire link
	input  wire logic [3:0]  AWADDR,  // write address
	input  wire logic        AWVALID, // write address valid
	output logic             AWREADY, // write address ready
	input  wire logic [31:0] WDATA,   // write data
	input  wire logic [3:0]  WSTRB,   // write strobes
	input  wire logic        WVALID,  // write data valid
	output logic             WREADY,  // write data ready
	output logic [1:0]       BRESP,   // write response
	output logic             BVALID,  // write response valid
	input  wire logic        BREADY,  // write response ready
	input  wire logic [3:0]  ARADDR,  // read address
	input  wire logic        ARVALID, // read address valid
	output logic             ARREADY, // read address ready
	output logic [31:0]      RDATA,   // read data
	output logic [1:0]       RRESP,   // read response
	output logic             RVALID,  // read valid
	input  wire logic        RREADY   // read ready
);
	typedef enum logic [5:0] {
		H_IDLE  = 6'b000001,
		H_START = 6'b000010,
		H_BIT   = 6'b000100,
		H_ACK   = 6'b001000,
		H_STOP  = 6'b010000,
		H_DONE  = 6'b100000
	} hst_t;

	typedef struct packed {
		hst_t        st;
		logic [7:0]  cnt;    // half-period timer
		logic        ph;     // 0 = scl low half, 1 = high half
		logic [1:0]  byten;  // 0 address, 1 data
		logic [3:0]  bitn;
		logic [7:0]  sh;
		logic        rd;
		logic [7:0]  wdat;
		logic [7:0]  rdat;
		logic        nack;
		logic        scl;
		logic        sda;
		logic [1:0]  sda_s;  // returned sda synchroniser
		logic        aw_got;
		logic        w_got;
		logic [31:0] wbuf;
		logic        wstb;   // byte-0 strobe taken with the data
		logic        bvalid;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} state_t;

	state_t s_q, s_d;
	logic tick;
	assign tick = (s_q.cnt == 8'(HALF_CYC - 1));

	////////////////////////////////////////////////////////////////////////
	// bus slave and bit engine
	always_comb begin
		s_d = s_q;
		s_d.sda_s = {s_q.sda_s[0], BUS.sda};
		s_d.cnt = (s_q.st == H_IDLE || tick) ? 8'h00 : s_q.cnt + 8'h01;
		// write channels taken in either order
		if (AWVALID && !s_q.aw_got && !s_q.bvalid) s_d.aw_got = 1'b1;
		if (WVALID && !s_q.w_got && !s_q.bvalid) begin
			s_d.w_got = 1'b1;
			s_d.wbuf = WDATA;
			s_d.wstb = WSTRB[0];
		end
		if (s_q.bvalid && BREADY) s_d.bvalid = 1'b0;
		// a command write during a transfer is answered okay and dropped
		if (s_q.aw_got && s_q.w_got) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			if (s_q.st == H_IDLE && s_q.wstb) begin
				s_d.st = H_START;
				s_d.rd = s_q.wbuf[CMD_RD_BIT];
				s_d.wdat = s_q.wbuf[7:0];
				s_d.sh = {s_q.wbuf[CMD_ADDR_LSB +: 7], s_q.wbuf[CMD_RD_BIT]};
				s_d.byten = 2'd0;
				s_d.nack = 1'b0;
				s_d.sda = 1'b0;
				s_d.cnt = 8'h00;
			end
		end
		if (ARVALID && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = (ARADDR == REG_STATUS || ARADDR == REG_CMD) ? RESP_OKAY : RESP_SLVERR;
			s_d.rdata = (ARADDR == REG_STATUS) ?
				{16'h0000, s_q.rdat, 6'h00, s_q.nack, (s_q.st != H_IDLE)} : 32'h0000_0000;
		end
		if (s_q.rvalid && RREADY) s_d.rvalid = 1'b0;
		if (tick) begin
			case (s_q.st)
				H_START: begin
					s_d.scl = 1'b0;
					s_d.ph = 1'b0;
					s_d.bitn = 4'h0;
					s_d.st = H_BIT;
					s_d.sda = s_q.sh[7];
				end
				H_BIT: begin
					if (!s_q.ph) begin
						s_d.scl = 1'b1;
						s_d.ph = 1'b1;
						if (s_q.rd && s_q.byten == 2'd1) s_d.sh = {s_q.sh[6:0], s_q.sda_s[1]};
					end else begin
						s_d.scl = 1'b0;
						s_d.ph = 1'b0;
						s_d.bitn = s_q.bitn + 4'h1;
						if (s_q.bitn == 4'h7) begin
							s_d.st = H_ACK;
							// release for slave ack; after a read byte the released line is the nack
							s_d.sda = 1'b1;
						end else begin
							if (!(s_q.rd && s_q.byten == 2'd1)) s_d.sh = {s_q.sh[6:0], 1'b0};
							s_d.sda = (s_q.rd && s_q.byten == 2'd1) ? 1'b1 : s_q.sh[6];
						end
					end
				end
				H_ACK: begin
					if (!s_q.ph) begin
						s_d.scl = 1'b1;
						s_d.ph = 1'b1;
						if (!(s_q.rd && s_q.byten == 2'd1) && s_q.sda_s[1]) s_d.nack = 1'b1;
					end else begin
						s_d.scl = 1'b0;
						s_d.ph = 1'b0;
						s_d.bitn = 4'h0;
						// data only follows an acknowledged address
						if (s_q.nack || s_q.byten == 2'd1) begin
							s_d.st = H_STOP;
							s_d.sda = 1'b0;
						end else begin
							s_d.byten = 2'd1;
							s_d.st = H_BIT;
							if (s_q.rd) begin
								s_d.sda = 1'b1;
							end else begin
								s_d.sh = s_q.wdat;
								s_d.sda = s_q.wdat[7];
							end
						end
						if (s_q.rd && s_q.byten == 2'd1) s_d.rdat = s_q.sh;
					end
				end
				H_STOP: begin
					if (!s_q.scl) begin
						s_d.scl = 1'b1;
					end else begin
						s_d.sda = 1'b1;
						s_d.st = H_DONE;
					end
				end
				H_DONE: s_d.st = H_IDLE;
				default: s_d.st = H_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge MCLK) begin
		if (RST) begin
			s_q <= '0;
			s_q.st <= H_IDLE;
			s_q.scl <= 1'b1;
			s_q.sda <= 1'b1;
			s_q.sda_s <= 2'b11;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign BUS.scl_o    = 1'b0;
	assign BUS.scl_oe   = !s_q.scl;
	assign BUS.sda_m_o  = 1'b0;
	assign BUS.sda_m_oe = !s_q.sda;
	assign AWREADY = !s_q.aw_got && !s_q.bvalid;
	assign WREADY  = !s_q.w_got && !s_q.bvalid;
	assign BVALID  = s_q.bvalid;
	assign BRESP   = RESP_OKAY;
	assign ARREADY = !s_q.rvalid;
	assign RVALID  = s_q.rvalid;
	assign RDATA   = s_q.rdata;
	assign RRESP   = s_q.rresp;
endmodule
`default_nettype wire

/* cvi_link_monitor.sv */
// concurrent checks on the two-wire link and the device outputs
`timescale 1ns/10ps
`default_nettype none
module cvi_link_monitor
	import cvi_pkg::*;
(
	input  wire logic       MCLK,           // system clock
	input  wire logic       RST,            // sync reset, high
	input  wire logic       scl,            // resolved clock line
	input  wire logic       sda,            // resolved data line
	input  wire logic       sda_s_oe,       // device pulls data low
	input  wire logic [3:0] VOLTAGE_SELECT, // code to reference DAC
	input  wire logic [3:0] SOFT_SRC_EN,    // soft-start source select
	input  wire logic [7:0] PROGRAM_REG     // program register view
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);
	////////////////////////////////////////////////////////////////
	// bus events as seen on the resolved lines
	sequence start_seq; scl && $fell(sda); endsequence
	sequence stop_seq; scl && $rose(sda); endsequence
	sequence drive_rise_seq; $rose(scl) && sda_s_oe; endsequence
	// longest legal hold: ack plus eight zero bits, with skew
	logic [7:0] hold_q;
	logic [7:0] hold_d;
	always_comb begin
		hold_d = sda_s_oe ? ((hold_q == 8'hFF) ? hold_q : hold_q + 8'h01) : 8'h00;
	end
	always_ff @(posedge MCLK) begin
		hold_q <= RST ? 8'h00 : hold_d;
	end
	////////////////////////////////////////////////////////////////
	chk_vsel_follow_prog: assert property ($stable(PROGRAM_REG) |-> VOLTAGE_SELECT == PROGRAM_REG[3:0])
		else $error("voltage select differs from program register");
	chk_src_one_hot: assert property ($stable(PROGRAM_REG) |-> SOFT_SRC_EN == (4'h1 << PROGRAM_REG[5:4]))
		else $error("soft-start source does not match slew code");
	chk_unused_bits_zero: assert property (PROGRAM_REG[7:6] == 2'b00)
		else $error("unused program bits not zero");
	chk_addr_phase_quiet: assert property (start_seq |-> !sda_s_oe [*8])
		else $error("device drives data right after start");
	chk_ack_hold_high: assert property (drive_rise_seq |-> sda_s_oe [*5])
		else $error("device drive dropped while clock high");
	chk_drive_clock_low: assert property ($changed(sda_s_oe) |-> !scl)
		else $error("device data changed while clock high");
	chk_latch_at_ack: assert property ($changed(PROGRAM_REG) |-> scl && !sda)
		else $error("program register changed outside ack high phase");
	chk_stop_released: assert property (stop_seq |-> !sda_s_oe [*8])
		else $error("device drives data after stop");
	chk_hold_bounded: assert property (hold_q <= 8'h78)
		else $error("device held data low too long");
endmodule
`default_nettype wire

/* core_voltage_i2c_slave_tb.sv */
// self-checking bench: host master and voltage device joined by the link
`timescale 1ns/10ps
`default_nettype none
module core_voltage_i2c_slave_tb;
	import cvi_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  aw_addr = 4'h0;
	logic        aw_valid = 1'b0;
	logic [31:0] w_data = 32'h0;
	logic        w_valid = 1'b0;
	logic        b_ready = 1'b0;
	logic [3:0]  ar_addr = 4'h0;
	logic        ar_valid = 1'b0;
	logic        r_ready = 1'b0;
	logic        aw_ready, w_ready, b_valid, ar_ready, r_valid;
	logic [1:0]  b_resp, r_resp, resp;
	logic [31:0] r_data, st, rdat;
	logic [3:0]  vsel, src_en;
	logic [7:0]  prog, d;
	logic [17:0] wire_bits = 18'h0;
	int          bit_cnt = 18;
	logic        scl_q = 1'b1;
	logic        sda_q = 1'b1;
	int          cycles = 0;
	int          miscompares = 0;
	int          checked = 0;
	////////////////////////////////////////////////////////////////
	cvi_if cvi_if_i ();
	cvi_host cvi_host_i (.MCLK(mclk), .RST(rst), .BUS(cvi_if_i.master), .AWADDR(aw_addr), .AWVALID(aw_valid),
		.AWREADY(aw_ready), .WDATA(w_data), .WSTRB(4'hF), .WVALID(w_valid), .WREADY(w_ready), .BRESP(b_resp),
		.BVALID(b_valid), .BREADY(b_ready), .ARADDR(ar_addr), .ARVALID(ar_valid), .ARREADY(ar_ready),
		.RDATA(r_data), .RRESP(r_resp), .RVALID(r_valid), .RREADY(r_ready));
	cvi_device cvi_device_i (.MCLK(mclk), .RST(rst), .BUS(cvi_if_i.slave), .VOLTAGE_SELECT(vsel),
		.SOFT_SRC_EN(src_en), .PROGRAM_REG(prog));
	cvi_link_monitor cvi_link_monitor_i (.MCLK(mclk), .RST(rst), .scl(cvi_if_i.scl), .sda(cvi_if_i.sda),
		.sda_s_oe(cvi_if_i.sda_s_oe), .VOLTAGE_SELECT(vsel), .SOFT_SRC_EN(src_en), .PROGRAM_REG(prog));
	////////////////////////////////////////////////////////////////
	// clock and hang guard
	always #2.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			report_and_stop();
		end
	end
	// first 18 wire bits after each start, sampled mid-cycle: an sda edge
	// launched with a scl fall must not look like a start
	always @(negedge mclk) begin
		if (scl_q && sda_q && cvi_if_i.scl === 1'b1 && cvi_if_i.sda === 1'b0) begin
			bit_cnt = 0;
			wire_bits = 18'h0;
		end else if (!scl_q && cvi_if_i.scl === 1'b1 && bit_cnt < 18) begin
			wire_bits = {wire_bits[16:0], cvi_if_i.sda};
			bit_cnt++;
		end
		scl_q = (cvi_if_i.scl === 1'b1);
		sda_q = (cvi_if_i.sda === 1'b1);
	end
	////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one AXI4-Lite access; readiness sampled at negedge, acted on at posedge
	task automatic axi_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic [1:0] rs);
		logic aw_t, w_t, ar_t, done;
		done = 1'b0;
		@(posedge mclk);
		aw_addr <= a;
		ar_addr <= a;
		w_data <= wd;
		aw_valid <= wr;
		w_valid <= wr;
		b_ready <= wr;
		ar_valid <= !wr;
		r_ready <= !wr;
		while (!done) begin
			@(negedge mclk);
			aw_t = aw_valid && (aw_ready === 1'b1);
			w_t = w_valid && (w_ready === 1'b1);
			ar_t = ar_valid && (ar_ready === 1'b1);
			done = wr ? (b_valid === 1'b1) : (r_valid === 1'b1);
			rs = wr ? b_resp : r_resp;
			rd = r_data;
			@(posedge mclk);
			if (aw_t) aw_valid <= 1'b0;
			if (w_t) w_valid <= 1'b0;
			if (ar_t) ar_valid <= 1'b0;
			if (done) b_ready <= 1'b0;
			if (done) r_ready <= 1'b0;
		end
	endtask
	// issue one link command, then poll until the master is idle
	task automatic link_cmd(input logic [6:0] a, input logic rd, input logic [7:0] wd, output logic [31:0] s);
		logic [31:0] x;
		logic [1:0]  rs;
		axi_xfer(1'b1, REG_CMD, (32'(a) << CMD_ADDR_LSB) | (32'(rd) << CMD_RD_BIT) | 32'(wd), x, rs);
		check(32'(rs), 32'(RESP_OKAY));
		s = 32'h1;
		while (s[0] !== 1'b0) axi_xfer(1'b0, REG_STATUS, 32'h0, s, rs);
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence: reset state, every slew code, wrong address, unmapped read
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		check(32'(prog), 32'h10);
		check(32'(src_en), 32'h2);
		link_cmd(DEV_ADDR, 1'b1, 8'h00, st);
		check(32'(st[15:8]), 32'h10);
		check(32'(wire_bits), {14'h0, DEV_ADDR, 2'b10, 8'h10, 1'b1});
		for (int i = 0; i < 4; i++) begin
			d = 8'hC0 | 8'(i << 4) | 8'(4'h9 ^ 4'(i * 3));
			link_cmd(DEV_ADDR, 1'b0, d, st);
			check(32'(st[1]), 32'h0);
			check(32'(wire_bits), {14'h0, DEV_ADDR, 2'b00, d, 1'b0});
			check(32'(prog), 32'(d & PROG_USED));
			check(32'(vsel), 32'(d[3:0]));
			check(32'(src_en), 32'h1 << i);
			check(32'({cvi_if_i.scl, cvi_if_i.sda}), 32'h3);
			link_cmd(DEV_ADDR, 1'b1, 8'h00, st);
			check(32'(st[15:8]), 32'(d & PROG_USED));
		end
		link_cmd(DEV_ADDR ^ 7'h01, 1'b0, 8'h05, st);
		check(32'(st[1]), 32'h1);
		check(32'(prog), 32'(d & PROG_USED));
		axi_xfer(1'b0, 4'hC, 32'h0, rdat, resp);
		check(32'(resp), 32'(RESP_SLVERR));
		check(rdat, 32'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
